// [include/flpc_pkg.sv]
// Package with the register map, field layout and timing of the FIFO/power block.
package flpc_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFF_RX_SKIP = 8'h78;
    localparam logic [7:0] OFF_RX_LEVEL = 8'h7C;
    localparam logic [7:0] OFF_TX_LEVEL = 8'h80;
    localparam logic [7:0] OFF_PM_CTRL = 8'h84;
    localparam logic [7:0] OFF_WAKE_WRITE = 8'h64;

    // ==========================================================
    // Field positions
    localparam int BIT_RX_SKIP = 31;
    localparam int BIT_PS_LO = 12;
    localparam int BIT_PHY_RESET = 10;
    localparam int BIT_FRAME_EN = 9;
    localparam int BIT_ENERGY_EN = 8;
    localparam int BIT_WAKE_PULSE = 3;
    localparam int BIT_WAKE_OUT_EN = 1;
    localparam int BIT_READY = 0;

    // ==========================================================
    // Reset values
    localparam logic [15:0] TX_FREE_RESET = 16'h1200;
    localparam logic [7:0] STS_USED_RESET = 8'h00;
    localparam logic [15:0] RX_USED_RESET = 16'h0000;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int PHY_RESET_US = 100;
    localparam int PHY_RESET_CYC = PHY_RESET_US * CLK_MHZ;
    localparam int WAKE_PULSE_MS = 50;
    localparam int WAKE_PULSE_CYC = WAKE_PULSE_MS * 1000 * CLK_MHZ;
    localparam int SKIP_CYC = 4;

    // ==========================================================
    // Power states
    typedef enum logic [1:0] {
        PS_NORMAL = 2'b00,
        PS_WAKE_FRAME = 2'b01,
        PS_ENERGY = 2'b10,
        PS_RESERVED = 2'b11
    } flpc_pstate_t;

    // Events from the MAC/FIFO side, one-cycle pulses.
    typedef struct packed {
        logic rx_frame_push;
        logic [15:0] rx_frame_len;
        logic rx_status_push;
        logic rx_status_pop;
        logic rx_data_pop;
        logic tx_data_push;
        logic tx_data_pop;
        logic tx_status_push;
        logic tx_status_pop;
        logic wake_frame_event;
        logic energy_event;
    } flpc_fifo_ev_t;

endpackage

// [core/flpc_regs.sv]
// FIFO level and power management control registers on APB.
`timescale 1ns/1ns
module flpc_regs
    import flpc_pkg::*;
#(
    parameter int PHY_RESET_CYCLES = PHY_RESET_CYC,
    parameter int WAKE_PULSE_CYCLES = WAKE_PULSE_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // FIFO and wake events
    input wire flpc_fifo_ev_t fifo_ev,
    // Receive skip handshake
    output logic rx_skip_to_next_frame,
    // Power and PHY
    output logic [1:0] power_state_select,
    output logic phy_reset,
    output logic wake_interrupt,
    output logic wake_out
);

    // ==========================================================
    // Bus decode
    logic acc;
    logic wr;
    logic rd;
    logic read_seen_q;
    logic [1:0] ps_q;
    logic wake_wr;
    logic ready;
    logic wr_ok;

    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign pready = 1'b1;
    assign ready = (ps_q == 2'b00);
    assign wake_wr = wr && (paddr == OFF_WAKE_WRITE);
    // Writes other than the wake write count only after a read, and only while ready.
    assign wr_ok = wr && read_seen_q && ready;
    assign pslverr = acc && !(paddr == OFF_RX_SKIP ||
        paddr == OFF_RX_LEVEL || paddr == OFF_TX_LEVEL ||
        paddr == OFF_PM_CTRL || paddr == OFF_WAKE_WRITE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_seen_q <= 1'b0;
        end else if (wake_wr && !ready) begin
            read_seen_q <= 1'b0;
        end else if (rd) begin
            read_seen_q <= 1'b1;
        end
    end

    // ==========================================================
    // Receive skip
    logic [2:0] skip_cnt_q;
    logic skip_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            skip_q <= 1'b0;
            skip_cnt_q <= 3'h0;
        end else if (skip_q) begin
            skip_cnt_q <= skip_cnt_q + 3'h1;
            if (skip_cnt_q == 3'(SKIP_CYC - 1)) begin
                skip_q <= 1'b0;
            end
        end else if (wr_ok && paddr == OFF_RX_SKIP &&
                pwdata[BIT_RX_SKIP]) begin
            skip_q <= 1'b1;
            skip_cnt_q <= 3'h0;
        end
    end
    assign rx_skip_to_next_frame = skip_q;

    // ==========================================================
    // FIFO levels
    logic [7:0] rx_sts_q;
    logic [15:0] rx_data_q;
    logic [7:0] tx_sts_q;
    logic [15:0] tx_free_q;
    logic [15:0] rx_len_up;

    assign rx_len_up = (fifo_ev.rx_frame_len + 16'h0003) & 16'hFFFC;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_sts_q <= STS_USED_RESET;
            tx_sts_q <= STS_USED_RESET;
        end else begin
            rx_sts_q <= rx_sts_q + 8'(fifo_ev.rx_status_push)
                - 8'(fifo_ev.rx_status_pop);
            tx_sts_q <= tx_sts_q + 8'(fifo_ev.tx_status_push)
                - 8'(fifo_ev.tx_status_pop);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data_q <= RX_USED_RESET;
            tx_free_q <= TX_FREE_RESET;
        end else begin
            // Data pops move one dword at a time.
            rx_data_q <= rx_data_q
                + (fifo_ev.rx_frame_push ? rx_len_up : 16'h0000)
                - (fifo_ev.rx_data_pop ? 16'h0004 : 16'h0000);
            tx_free_q <= tx_free_q
                - (fifo_ev.tx_data_push ? 16'h0004 : 16'h0000)
                + (fifo_ev.tx_data_pop ? 16'h0004 : 16'h0000);
        end
    end

    // ==========================================================
    // Power management control
    logic wake_frame_enable_q;
    logic energy_detect_enable_q;
    logic pulse_mode_q;
    logic out_en_q;
    logic pm_wr;

    assign pm_wr = wr_ok && paddr == OFF_PM_CTRL;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ps_q <= 2'b00;
        end else if (wake_wr && !ready) begin
            ps_q <= 2'b00;
        end else if (pm_wr &&
                pwdata[BIT_PS_LO+1:BIT_PS_LO] != PS_RESERVED) begin
            ps_q <= pwdata[BIT_PS_LO+1:BIT_PS_LO];
        end
    end
    assign power_state_select = ps_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_frame_enable_q <= 1'b0;
            energy_detect_enable_q <= 1'b0;
            pulse_mode_q <= 1'b0;
            out_en_q <= 1'b0;
        end else if (pm_wr) begin
            wake_frame_enable_q <= pwdata[BIT_FRAME_EN];
            energy_detect_enable_q <= pwdata[BIT_ENERGY_EN];
            pulse_mode_q <= pwdata[BIT_WAKE_PULSE];
            out_en_q <= pwdata[BIT_WAKE_OUT_EN];
        end
    end

    // ==========================================================
    // PHY reset timer
    logic phy_reset_request_q;
    logic [31:0] phy_cnt_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phy_reset_request_q <= 1'b0;
            phy_cnt_q <= 32'h0;
        end else if (phy_reset_request_q) begin
            phy_cnt_q <= phy_cnt_q + 32'h1;
            if (phy_cnt_q == 32'(PHY_RESET_CYCLES - 1)) begin
                phy_reset_request_q <= 1'b0;
            end
        end else if (pm_wr && pwdata[BIT_PHY_RESET]) begin
            // While high, writes never reach this branch.
            phy_reset_request_q <= 1'b1;
            phy_cnt_q <= 32'h0;
        end
    end
    assign phy_reset = phy_reset_request_q;

    // ==========================================================
    // Wake indication
    logic wake_ev;
    logic int_q;
    logic pin_q;
    logic [31:0] pulse_cnt_q;

    assign wake_ev = (wake_frame_enable_q && fifo_ev.wake_frame_event) ||
        (energy_detect_enable_q && fifo_ev.energy_event);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_q <= 1'b0;
        end else if (wake_ev) begin
            int_q <= 1'b1;
        end else if (!wake_frame_enable_q && !energy_detect_enable_q) begin
            int_q <= 1'b0;
        end
    end
    assign wake_interrupt = int_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q <= 1'b0;
            pulse_cnt_q <= 32'h0;
        end else if (wake_ev && out_en_q) begin
            pin_q <= 1'b1;
            pulse_cnt_q <= 32'h0;
        end else if (!out_en_q) begin
            pin_q <= 1'b0;
        end else if (pin_q && pulse_mode_q) begin
            pulse_cnt_q <= pulse_cnt_q + 32'h1;
            if (pulse_cnt_q == 32'(WAKE_PULSE_CYCLES - 1)) begin
                pin_q <= 1'b0;
            end
        end
    end
    assign wake_out = pin_q;

    // ==========================================================
    // Read data, registered on the setup cycle of a read.
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;

    always_comb begin
        rdata_d = 32'h0;
        unique case (paddr)
            OFF_RX_SKIP: rdata_d[BIT_RX_SKIP] = skip_q;
            OFF_RX_LEVEL: rdata_d = {8'h00, rx_sts_q, rx_data_q};
            OFF_TX_LEVEL: rdata_d = {8'h00, tx_sts_q, tx_free_q};
            OFF_PM_CTRL: begin
                // Readable whatever the power state.
                rdata_d[BIT_PS_LO+1:BIT_PS_LO] = ps_q;
                rdata_d[BIT_PHY_RESET] = phy_reset_request_q;
                rdata_d[BIT_FRAME_EN] = wake_frame_enable_q;
                rdata_d[BIT_ENERGY_EN] = energy_detect_enable_q;
                rdata_d[BIT_WAKE_PULSE] = pulse_mode_q;
                rdata_d[BIT_WAKE_OUT_EN] = out_en_q;
                rdata_d[BIT_READY] = ready;
            end
            default: rdata_d = 32'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            rdata_q <= rdata_d;
        end
    end
    assign prdata = rdata_q;

    // ==========================================================
    // Checks
    AST_SKIP_LEN: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(skip_q) |-> skip_q [*4] ##1 !skip_q)
        else $error("skip bit length wrong");
    AST_SKIP_START: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_ok && paddr == OFF_RX_SKIP && pwdata[BIT_RX_SKIP] && !skip_q)
        |=> skip_q)
        else $error("skip did not start");
    AST_NOREAD_WR: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && !read_seen_q && paddr == OFF_PM_CTRL) |=> $stable(wake_frame_enable_q))
        else $error("write taken before read");
    AST_PHY_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(phy_reset_request_q) |-> phy_reset_request_q [*8])
        else $error("phy reset too short");
    AST_PHY_IGN: assert property (@(posedge pclk) disable iff (!presetn)
        (phy_reset_request_q && pm_wr) |=> phy_cnt_q == $past(phy_cnt_q) + 32'h1)
        else $error("phy reset restarted");
    AST_WAKE_INT: assert property (@(posedge pclk) disable iff (!presetn)
        wake_ev |=> int_q)
        else $error("interrupt missed");
    AST_ED_PIN: assert property (@(posedge pclk) disable iff (!presetn)
        (energy_detect_enable_q && fifo_ev.energy_event && out_en_q) |=> pin_q)
        else $error("pin missed energy event");
    AST_PIN_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        !out_en_q |=> !pin_q)
        else $error("pin active while disabled");
    AST_WAKE_RDY: assert property (@(posedge pclk) disable iff (!presetn)
        (wake_wr && !ready) |=> ready)
        else $error("wake write ignored");
    AST_RX_LVL: assert property (@(posedge pclk) disable iff (!presetn)
        (fifo_ev.rx_frame_push && !fifo_ev.rx_data_pop) |=>
        rx_data_q == $past(rx_data_q) +
        {$past(fifo_ev.rx_frame_len[15:2]) +
        14'(|$past(fifo_ev.rx_frame_len[1:0])), 2'b00})
        else $error("rx level wrong");

endmodule

// [test/flpc_mac_model.sv]
// Model of the MAC side that raises FIFO and wake event pulses.
`timescale 1ns/1ns
module flpc_mac_model
    import flpc_pkg::*;
(
    // Clock
    input wire logic pclk,
    // Block side
    input wire logic rx_skip_to_next_frame,
    output flpc_fifo_ev_t fifo_ev
);
    int tx_free = TX_FREE_RESET;
    initial fifo_ev = '0;
    // ======
    // Event pulse
    task automatic pulse(input flpc_fifo_ev_t e);
        while (e.rx_data_pop && rx_skip_to_next_frame) begin
            @(posedge pclk);
        end
        if (e.tx_data_push && tx_free < 4) begin
            e.tx_data_push = 1'b0;
        end
        tx_free += (e.tx_data_pop ? 4 : 0) - (e.tx_data_push ? 4 : 0);
        fifo_ev <= e;
        @(posedge pclk);
        fifo_ev <= '0;
        @(posedge pclk);
    endtask
endmodule

// [test/tb.sv]
// Self-checking bench for the FIFO level and power control registers.
`timescale 1ns/1ns
module tb;
    import flpc_pkg::*;
    localparam int PRC = 20;
    localparam int WPC = 30;
    localparam logic [31:0] PMM = 32'h0000370B;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic skip;
    logic [1:0] pss;
    logic phy;
    logic wint;
    logic wout;
    flpc_fifo_ev_t ev_s;
    logic [64:0] expq[$];
    logic [64:0] got;
    logic [31:0] seed = 32'h0000001E;
    int mismatches = 0;
    int compares = 0;
    int cyc = 0;

    flpc_regs #(.PHY_RESET_CYCLES(PRC), .WAKE_PULSE_CYCLES(WPC)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fifo_ev(ev_s),
        .rx_skip_to_next_frame(skip), .power_state_select(pss),
        .phy_reset(phy), .wake_interrupt(wint), .wake_out(wout)
    );
    flpc_mac_model mac (
        .pclk(pclk), .rx_skip_to_next_frame(skip), .fifo_ev(ev_s)
    );
    always #5 pclk = ~pclk;

    // ======
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic check(input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("Compares %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, e,
                      input logic err = 1'b0);
        expq.push_back({err, m, e});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic ev(input logic [9:0] f, input logic [15:0] n = 16'h0);
        mac.pulse(flpc_fifo_ev_t'({f[9], n, f[8:0]}));
    endtask

    // Read results are compared against the oldest note.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            close_out();
        end
        if (psel && penable && !pwrite && pready === 1'b1) begin
            got = expq.pop_front();
            check(prdata & got[63:32], got[31:0]);
            check({31'h0, pslverr}, {31'h0, got[64]});
        end
    end

    // ======
    // Main sequence
    initial begin
        logic [15:0] len;
        logic [31:0] cfg;
        int rxu;
        int t0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b1, OFF_PM_CTRL, 32'h00000200);
        rd(OFF_PM_CTRL, PMM, 32'h00000001);
        rd(OFF_RX_LEVEL, 32'h00FFFFFF, 32'h0);
        rd(OFF_TX_LEVEL, 32'h00FFFFFF, 32'h00001200);
        rd(OFF_RX_SKIP, 32'h80000000, 32'h0);
        rd(8'h90, 32'hFFFFFFFF, 32'h0, 1'b1);
        apb(1'b1, OFF_PM_CTRL, 32'h00003000);
        check({30'h0, pss}, 32'h0);
        rxu = 0;
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            len = {5'h0, seed[10:0]} + 16'h1;
            rxu += (int'(len) + 3) & ~3;
            ev(10'h300, len);
            ev(10'h028);
        end
        rd(OFF_RX_LEVEL, 32'h00FFFFFF, {16'h06, rxu[15:0]});
        rd(OFF_TX_LEVEL, 32'h00FFFFFF, 32'h000611E8);
        ev(10'h0D4);
        ev(10'h0D4);
        rxu -= 8;
        rd(OFF_RX_LEVEL, 32'h00FFFFFF, {16'h04, rxu[15:0]});
        rd(OFF_TX_LEVEL, 32'h00FFFFFF, 32'h000411F0);
        apb(1'b1, OFF_RX_SKIP, 32'h80000000);
        check({31'h0, skip}, 32'h1);
        rd(OFF_RX_SKIP, 32'h80000000, 32'h80000000);
        ev(10'h040);
        rd(OFF_RX_SKIP, 32'h80000000, 32'h0);
        apb(1'b1, OFF_PM_CTRL, 32'h00000400);
        t0 = cyc;
        rd(OFF_PM_CTRL, 32'h00000400, 32'h00000400);
        apb(1'b1, OFF_PM_CTRL, 32'h0);
        check({31'h0, phy}, 32'h1);
        while (phy === 1'b1) @(posedge pclk);
        t0 = cyc - t0;
        check({31'h0, t0 >= PRC && t0 <= PRC + 2}, 32'h1);
        rd(OFF_PM_CTRL, 32'h00000400, 32'h0);
        for (int i = 0; i < 8; i++) begin
            cfg = i[0] ? 32'h00001200 : 32'h00002100;
            cfg = cfg | {28'h0, i[2], 1'b0, i[1], 1'b0};
            apb(1'b1, OFF_PM_CTRL, cfg);
            check({30'h0, pss}, {30'h0, cfg[13:12]});
            rd(OFF_PM_CTRL, PMM, cfg);
            ev(i[0] ? 10'h001 : 10'h002);
            check({31'h0, wint}, 32'h0);
            ev(i[0] ? 10'h002 : 10'h001);
            check({30'h0, wint, wout}, {30'h0, 1'b1, i[1]});
            repeat (WPC + 4) @(posedge pclk);
            check({31'h0, wout}, {31'h0, i[1] & ~i[2]});
            seed = xs(seed);
            apb(1'b1, OFF_WAKE_WRITE, seed);
            check({30'h0, pss}, 32'h0);
            apb(1'b1, OFF_PM_CTRL, 32'h0);
            rd(OFF_PM_CTRL, PMM, {cfg[31:14], 2'b00, cfg[11:1], 1'b1});
            apb(1'b1, OFF_PM_CTRL, 32'h0);
            // Interrupt and pin drop one edge after the enables clear.
            @(posedge pclk);
            check({30'h0, wint, wout}, 32'h0);
        end
        close_out();
    end
endmodule
